//--- rtl/lqm_pkg.sv
// Purpose: shared constants and carriers for the variance readout and link quality monitor
// Assumes: 20 MHz clock, APB register access, one word per register index
// Notes:   register byte address is four times the index
// Operation
// - variance data counts as valid only while the ready flag is set
// - 32-bit variance sum read through a 16-bit field, two reads needed
// - after freeze, first read gives low half, second read gives high half
// - monitor enable acts only while a valid 100 Mb link exists
// - threshold set to its maximum or minimum is never reported exceeded
// - first threshold violation since the last monitor register read raises the link quality interrupt when enabled
// - reading the monitor register clears warnings and re-arms the interrupt
// - warning bits 9 to 0 map to each parameter's high and low threshold
// - monitor register bits 14:10 ignore writes and read as zero
// - optional automatic 100 Mb link reset driven by monitor status
// - ready flag sets whenever a new variance sum is loaded while freeze is clear
// - freeze and ready clear after two consecutive variance data reads
package lqm_pkg;

    // register indices
    localparam logic [5:0] VAR_CTRL_IDX   = 6'h1A;
    localparam logic [5:0] VAR_DATA_IDX   = 6'h1B;
    localparam logic [5:0] LQM_IDX        = 6'h1D;
    localparam logic [5:0] AUTO_CTRL_IDX  = 6'h20;
    localparam logic [5:0] INT_STATUS_IDX = 6'h21;
    localparam logic [5:0] INT_ENABLE_IDX = 6'h22;
    localparam logic [5:0] INT_CLEAR_IDX  = 6'h23;

    // field positions
    localparam int VAR_READY_BIT  = 15;
    localparam int VAR_FREEZE_BIT = 3;
    localparam int VAR_TIMER_LSB  = 1;
    localparam int VAR_ENABLE_BIT = 0;
    localparam int MON_ENABLE_BIT = 15;
    localparam int AUTO_RESET_BIT = 0;
    localparam int INT_LQ_BIT     = 0;
    localparam int INT_VAR_BIT    = 1;

    // monitored parameters: index i owns warning bits 2i (low) and 2i+1 (high)
    localparam int N_PARAMS  = 5;
    localparam int N_WARN    = 10;
    localparam int N_INT     = 2;
    localparam int LQ_VAL_W  = 8;

    // reset values
    localparam logic [N_WARN-1:0] WARN_RESET = 10'h000;
    localparam logic [N_INT-1:0]  INT_RESET  = 2'h0;
    localparam logic [31:0]       DATA_RESET = 32'h0000_0000;
    localparam logic [1:0]        TIMER_RESET = 2'h0;

    typedef struct packed {
        logic [LQ_VAL_W-1:0] value;
        logic [LQ_VAL_W-1:0] high;
        logic [LQ_VAL_W-1:0] low;
    } lq_sample_type;

    typedef lq_sample_type [N_PARAMS-1:0] lq_bank_type;

    typedef struct packed {
        logic                link_meta;
        logic                link_ok;
        logic [31:0]         var_data;
        logic                var_ready;
        logic                freeze;
        logic [1:0]          var_timer;
        logic                var_enable;
        logic                read_high;
        logic                monitor_enable;
        logic [N_WARN-1:0]   warnings;
        logic                armed;
        logic                auto_reset_en;
        logic [N_INT-1:0]    int_status;
        logic [N_INT-1:0]    int_enable;
        logic                link_reset;
        logic [31:0]         prdata;
        logic                pslverr;
    } lqm_state_type;

    typedef struct packed {
        logic over_high;
        logic under_low;
    } thr_flags_type;

endpackage

//--- rtl/threshold_check.sv
// Purpose: registered high/low threshold comparison for one monitored parameter
// Assumes: unsigned values, thresholds stable while compared
// Notes:   one cycle of latency from value to flag
`timescale 1ns/100ps
module threshold_check
    import lqm_pkg::*;
#(
    parameter int W = LQ_VAL_W
)
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // parameter and limits
    input  wire logic [W-1:0]  value,
    input  wire logic [W-1:0]  high,
    input  wire logic [W-1:0]  low,
    // flags
    output thr_flags_type      flags
);

    thr_flags_type st;
    thr_flags_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.over_high = (high != {W{1'b1}}) && (value > high);
        next_st.under_low = (low != {W{1'b0}}) && (value < low);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign flags = st;

    AST_MAX_NEVER_HIGH: assert property (@(posedge clock) disable iff (rst)
        (high == {W{1'b1}}) |=> !st.over_high)
        else $error("high flag set with threshold at maximum");

    AST_MIN_NEVER_LOW: assert property (@(posedge clock) disable iff (rst)
        (low == {W{1'b0}}) |=> !st.under_low)
        else $error("low flag set with threshold at minimum");

endmodule

//--- rtl/lqm_regs.sv
// Purpose: variance sum readout and link quality monitor registers on APB
// Assumes: variance sum and parameters come from logic on the same clock
// Notes:   link valid arrives from another domain and is synchronised
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module lqm_regs
    import lqm_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // apb slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // variance computation
    input  wire logic [31:0]       var_sum,
    input  wire logic              var_sum_load,
    output logic                   var_enable,
    output logic [1:0]             var_timer,
    // link quality
    input  wire logic              link_100_valid,
    input  wire lq_bank_type       lq_bank,
    output logic                   link_reset,
    // interrupt
    output logic                   irq
);

    lqm_state_type      st;
    lqm_state_type      next_st;
    thr_flags_type      flags [N_PARAMS];
    logic [N_WARN-1:0]  viol;
    logic               mon_active;
    logic               setup;
    logic               wr_access;
    logic               rd_access;
    logic [5:0]         idx;
    logic [31:0]        rd_word;
    logic               lq_event;

    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[7:2];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [5:0] i;
        i = reg_index(a);
        is_mapped = (a[1:0] == 2'h0) && ((a >> 8) == '0)
            && (i == VAR_CTRL_IDX || i == VAR_DATA_IDX || i == LQM_IDX
            || i == AUTO_CTRL_IDX || i == INT_STATUS_IDX || i == INT_ENABLE_IDX
            || i == INT_CLEAR_IDX);
    endfunction

    for (genvar g = 0; g < N_PARAMS; g++)
    begin : gen_thr
        threshold_check #(.W(LQ_VAL_W)) u_thr (
            .clock (clock),
            .rst   (rst),
            .value (lq_bank[g].value),
            .high  (lq_bank[g].high),
            .low   (lq_bank[g].low),
            .flags (flags[g])
        );
        // high on odd, low on even
        assign viol[2*g+1] = flags[g].over_high;
        assign viol[2*g]   = flags[g].under_low;
    end

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite && is_mapped(paddr);
    assign rd_access = psel && penable && !pwrite && is_mapped(paddr);
    assign idx       = reg_index(paddr);
    assign mon_active = st.monitor_enable && st.link_ok;
    assign lq_event   = mon_active && (|viol) && (st.armed || (rd_access && idx == LQM_IDX));

    // read word mux, sampled in the setup cycle so prdata is a flop
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (idx)
            VAR_CTRL_IDX:
            begin
                rd_word[VAR_READY_BIT]  = st.var_ready;
                rd_word[VAR_FREEZE_BIT] = st.freeze;
                rd_word[VAR_TIMER_LSB+:2] = st.var_timer;
                rd_word[VAR_ENABLE_BIT] = st.var_enable;
            end
            VAR_DATA_IDX:   rd_word[15:0] = st.read_high ? st.var_data[31:16]
                                                         : st.var_data[15:0];
            LQM_IDX:
            begin
                rd_word[MON_ENABLE_BIT] = st.monitor_enable;
                rd_word[N_WARN-1:0]     = st.warnings;
            end
            AUTO_CTRL_IDX:  rd_word[AUTO_RESET_BIT] = st.auto_reset_en;
            INT_STATUS_IDX: rd_word[N_INT-1:0] = st.int_status;
            INT_ENABLE_IDX: rd_word[N_INT-1:0] = st.int_enable;
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.link_meta  = link_100_valid;
        next_st.link_ok    = st.link_meta;
        next_st.link_reset = 1'b0;

        if (setup)
        begin
            // refused addresses read zero, never a neighbour's data
            next_st.prdata  = is_mapped(paddr) ? rd_word : 32'h0000_0000;
            next_st.pslverr = !is_mapped(paddr);
        end

        if (wr_access)
        begin
            unique case (idx)
                VAR_CTRL_IDX:
                begin
                    next_st.freeze     = pwdata[VAR_FREEZE_BIT];
                    next_st.var_timer  = pwdata[VAR_TIMER_LSB+:2];
                    next_st.var_enable = pwdata[VAR_ENABLE_BIT];
                    if (pwdata[VAR_FREEZE_BIT])
                        next_st.read_high = 1'b0;
                end
                LQM_IDX:        next_st.monitor_enable = pwdata[MON_ENABLE_BIT];
                AUTO_CTRL_IDX:  next_st.auto_reset_en  = pwdata[AUTO_RESET_BIT];
                INT_ENABLE_IDX: next_st.int_enable     = pwdata[N_INT-1:0];
                INT_CLEAR_IDX:  next_st.int_status     = st.int_status & ~pwdata[N_INT-1:0];
                default:        next_st.int_enable     = st.int_enable;
            endcase
        end

        if (rd_access && idx == VAR_DATA_IDX)
        begin
            if (st.read_high)
            begin
                next_st.read_high = 1'b0;
                next_st.freeze    = 1'b0;
                next_st.var_ready = 1'b0;
            end
            else
                next_st.read_high = 1'b1;
        end

        if (rd_access && idx == LQM_IDX)
        begin
            next_st.warnings = WARN_RESET;
            next_st.armed    = 1'b1;
        end

        if (mon_active)
            next_st.warnings = next_st.warnings | viol;

        if (lq_event)
        begin
            next_st.armed = 1'b0;
            next_st.int_status[INT_LQ_BIT] = 1'b1;
            next_st.link_reset = st.auto_reset_en;
        end

        if (var_sum_load && !st.freeze)
        begin
            next_st.var_data  = var_sum;
            next_st.var_ready = 1'b1;
            next_st.read_high = 1'b0;
            next_st.int_status[INT_VAR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st            <= '0;
            st.var_data   <= DATA_RESET;
            st.var_timer  <= TIMER_RESET;
            st.warnings   <= WARN_RESET;
            st.int_status <= INT_RESET;
            st.int_enable <= INT_RESET;
            // disarmed until the first monitor read
            st.armed      <= 1'b0;
        end
        else
            st <= next_st;
    end

    // zero wait states: the word was captured in the setup cycle
    assign pready     = psel && penable;
    assign prdata     = st.prdata;
    assign pslverr    = st.pslverr;
    assign var_enable = st.var_enable;
    assign var_timer  = st.var_timer;
    assign link_reset = st.link_reset;
    assign irq        = |(st.int_status & st.int_enable);

    AST_READY_ON_LOAD: assert property (@(posedge clock) disable iff (rst)
        (var_sum_load && !st.freeze) |=> st.var_ready && st.var_data == $past(var_sum))
        else $error("load did not set ready with new sum");

    AST_FROZEN_STABLE: assert property (@(posedge clock) disable iff (rst)
        st.freeze |=> $stable(st.var_data))
        else $error("variance data changed while frozen");

    AST_HALF_ORDER: assert property (@(posedge clock) disable iff (rst)
        (setup && !pwrite && is_mapped(paddr) && idx == VAR_DATA_IDX && !st.read_high)
        |=> st.prdata[15:0] == $past(st.var_data[15:0]) && st.prdata[31:16] == 16'h0000)
        else $error("first variance read not low half");

    AST_HIGH_SECOND: assert property (@(posedge clock) disable iff (rst)
        (rd_access && idx == VAR_DATA_IDX && !st.read_high && !var_sum_load)
        |=> st.read_high)
        else $error("second variance read would not give high half");

    AST_AUTO_CLEAR: assert property (@(posedge clock) disable iff (rst)
        (rd_access && idx == VAR_DATA_IDX && st.read_high && st.freeze)
        |=> !st.freeze && !st.var_ready)
        else $error("freeze or ready not cleared after two reads");

    AST_NO_LINK_NO_WARN: assert property (@(posedge clock) disable iff (rst)
        !st.link_ok |=> (st.warnings & ~$past(st.warnings)) == '0)
        else $error("warning set without valid link");

    AST_VIOL_MAP: assert property (@(posedge clock) disable iff (rst)
        (mon_active && flags[4].over_high) |=> st.warnings[9])
        else $error("frequency control high warning not at bit 9");

    AST_READ_CLEARS: assert property (@(posedge clock) disable iff (rst)
        (rd_access && idx == LQM_IDX && !mon_active) |=> st.warnings == '0 && st.armed)
        else $error("monitor read did not clear and re-arm");

    AST_STICKY: assert property (@(posedge clock) disable iff (rst)
        (st.warnings[0] && !(rd_access && idx == LQM_IDX)) |=> st.warnings[0])
        else $error("warning dropped without a read");

    AST_EVENT_IRQ: assert property (@(posedge clock) disable iff (rst)
        (lq_event && st.int_enable[INT_LQ_BIT] && !psel) |=> irq [*2])
        else $error("violation did not raise enabled interrupt");

    AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst)
        (setup && idx == LQM_IDX) |=> st.prdata[14:10] == 5'h00)
        else $error("reserved monitor bits not zero");

    AST_LINK_RESET: assert property (@(posedge clock) disable iff (rst)
        (lq_event && st.auto_reset_en) |=> link_reset ##1 !link_reset)
        else $error("auto link reset pulse missing");

    AST_UNMAPPED_ERR: assert property (@(posedge clock) disable iff (rst)
        (setup && !is_mapped(paddr)) |=> pslverr && prdata == 32'h0000_0000)
        else $error("refused address did not give error and zero");

    AST_MAPPED_OK: assert property (@(posedge clock) disable iff (rst)
        (setup && is_mapped(paddr)) |=> !pslverr)
        else $error("mapped address gave an error");

    AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (rst)
        (wr_access && idx == LQM_IDX) |=> st.monitor_enable == $past(pwdata[MON_ENABLE_BIT]))
        else $error("monitor enable not taken from bit 15");

    AST_DATA_UPPER_ZERO: assert property (@(posedge clock) disable iff (rst)
        (setup && idx == VAR_DATA_IDX) |=> st.prdata[31:16] == 16'h0000)
        else $error("variance data upper bits not zero");

    AST_SECOND_HIGH: assert property (@(posedge clock) disable iff (rst)
        (setup && !pwrite && is_mapped(paddr) && idx == VAR_DATA_IDX && st.read_high)
        |=> st.prdata[15:0] == $past(st.var_data[31:16]))
        else $error("second variance read not high half");

    AST_READY_HOLDS: assert property (@(posedge clock) disable iff (rst)
        (st.var_ready && !(rd_access && idx == VAR_DATA_IDX)) |=> st.var_ready)
        else $error("ready dropped without data reads");

    AST_FROZEN_NO_READY: assert property (@(posedge clock) disable iff (rst)
        (var_sum_load && st.freeze && !st.var_ready) |=> !st.var_ready)
        else $error("frozen load raised ready");

    AST_STATUS_ON_LOAD: assert property (@(posedge clock) disable iff (rst)
        (var_sum_load && !st.freeze) |=> st.int_status[INT_VAR_BIT])
        else $error("load did not set variance status");

    AST_FREEZE_RESTARTS: assert property (@(posedge clock) disable iff (rst)
        (wr_access && idx == VAR_CTRL_IDX && pwdata[VAR_FREEZE_BIT])
        |=> st.freeze && !st.read_high)
        else $error("freeze write did not restart at low half");

    AST_EVENT_STATUS: assert property (@(posedge clock) disable iff (rst)
        lq_event |=> st.int_status[INT_LQ_BIT] && !st.armed)
        else $error("event did not set status and disarm");

    AST_DISARMED_QUIET: assert property (@(posedge clock) disable iff (rst)
        (!st.armed && !(rd_access && idx == LQM_IDX) && !wr_access)
        |=> $stable(st.int_status[INT_LQ_BIT]))
        else $error("status changed while disarmed");

    AST_READ_REARMS: assert property (@(posedge clock) disable iff (rst)
        (rd_access && idx == LQM_IDX && !lq_event) |=> st.armed)
        else $error("monitor read did not re-arm");

    AST_VIOL_MAP_LOW: assert property (@(posedge clock) disable iff (rst)
        (mon_active && flags[0].under_low) |=> st.warnings[0])
        else $error("equalizer low warning not at bit 0");

    AST_VIOL_MAP_MID: assert property (@(posedge clock) disable iff (rst)
        (mon_active && flags[2].over_high) |=> st.warnings[5])
        else $error("baseline wander high warning not at bit 5");

    AST_NO_ENABLE_NO_WARN: assert property (@(posedge clock) disable iff (rst)
        !st.monitor_enable |=> (st.warnings & ~$past(st.warnings)) == '0)
        else $error("warning set with monitor disabled");

    AST_LINK_SYNC: assert property (@(posedge clock) disable iff (rst)
        st.link_meta |=> st.link_ok)
        else $error("link valid lost in synchroniser");

    AST_NO_AUTO_NO_RESET: assert property (@(posedge clock) disable iff (rst)
        !st.auto_reset_en |=> !link_reset)
        else $error("link reset pulse without auto reset enabled");

    AST_INT_ENABLE_WRITE: assert property (@(posedge clock) disable iff (rst)
        (wr_access && idx == INT_ENABLE_IDX) |=> st.int_enable == $past(pwdata[N_INT-1:0]))
        else $error("interrupt enable write not taken");

    COV_VAR_READOUT: cover property (@(posedge clock) disable iff (rst)
        rd_access && idx == VAR_DATA_IDX && st.read_high && st.freeze);
    COV_LQ_IRQ: cover property (@(posedge clock) disable iff (rst) lq_event ##1 irq);
    COV_REARM: cover property (@(posedge clock) disable iff (rst)
        (rd_access && idx == LQM_IDX) ##[1:50] lq_event);
    COV_AUTO_RESET: cover property (@(posedge clock) disable iff (rst) link_reset);
    COV_FROZEN_LOAD: cover property (@(posedge clock) disable iff (rst) var_sum_load && st.freeze);

endmodule

//--- sim/variance_readout_link_quality_monitor_bench.sv
// Purpose: self-checking bench for the variance readout and link quality registers
// Assumes: zero-wait APB slave, unsigned thresholds, strict exceed
// Notes:   reads are queued by the driver and compared by a watcher at completion
`timescale 1ns/100ps
module variance_readout_link_quality_monitor_bench import lqm_pkg::*;;
    logic        clock;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] var_sum;
    logic        var_sum_load;
    logic        var_enable;
    logic [1:0]  var_timer;
    logic        link_100_valid;
    lq_bank_type lq_bank;
    logic        link_reset;
    logic        irq;
    logic [32:0] exp_q[$];
    logic [31:0] seed;
    logic [31:0] r;
    int          bad_count;
    int          n_tests;
    int          cycles;
    int          resets;

    lqm_regs #(.ADDR_W(8)) uut (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .var_sum(var_sum), .var_sum_load(var_sum_load),
        .var_enable(var_enable), .var_timer(var_timer), .link_100_valid(link_100_valid),
        .lq_bank(lq_bank), .link_reset(link_reset), .irq(irq)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] addr_of(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // request held until pready is sampled high; a hang is cut by the cycle ceiling
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [32:0] exp);
        @(posedge clock);
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= wd;
        psel    <= 1'b1;
        penable <= 1'b0;
        if (!wr)
            exp_q.push_back(exp);
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b0, addr_of(idx), 32'h0000_0000, {1'b0, d});
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, addr_of(idx), d, 33'h0_0000_0000);
    endtask

    // outputs are looked at mid-cycle, once the edge's updates have landed
    task automatic check_irq(input logic e);
        @(negedge clock);
        check("irq", {32'h0000_0000, irq}, {32'h0000_0000, e});
    endtask

    task automatic load_sum(input logic [31:0] v);
        @(posedge clock);
        var_sum      <= v;
        var_sum_load <= 1'b1;
        @(posedge clock);
        var_sum_load <= 1'b0;
    endtask

    task automatic set_value(input int i, input logic [7:0] v);
        @(posedge clock);
        lq_bank[i].value <= v;
        repeat (5) @(posedge clock);
    endtask

    // watcher: every completed read takes the oldest expectation
    always @(posedge clock)
    begin
        if (psel && penable && pready && !pwrite)
            check("prdata", {pslverr, prdata}, exp_q.pop_front());
    end

    always @(posedge clock)
    begin
        if (link_reset === 1'b1)
            resets++;
    end

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        var_sum = 32'h0000_0000;
        var_sum_load = 1'b0;
        link_100_valid = 1'b0;
        seed = 32'hDC93;
        for (int i = 0; i < N_PARAMS; i++)
        begin
            seed = lfsr(seed);
            lq_bank[i].value = 8'h80;
            lq_bank[i].high  = 8'hA0 + {3'h0, seed[4:0]};
            lq_bank[i].low   = 8'h20 + {3'h0, seed[12:8]};
        end
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(VAR_CTRL_IDX, 32'h0000_0000);
        rd(VAR_DATA_IDX, 32'h0000_0000);
        rd(LQM_IDX, 32'h0000_0000);
        apb(1'b0, 8'hFC, 32'h0000_0000, 33'h1_0000_0000);
        apb(1'b0, 8'h6D, 32'h0000_0000, 33'h1_0000_0000);
        wr(VAR_CTRL_IDX, 32'h0000_0007);
        check_irq(1'b0);
        check("var_ctl", {30'h0, var_timer, var_enable}, 33'h0_0000_0007);
        seed = lfsr(seed);
        r = seed;
        load_sum(r);
        rd(VAR_CTRL_IDX, 32'h0000_8007);
        rd(INT_STATUS_IDX, 32'h0000_0002);
        wr(INT_ENABLE_IDX, 32'h0000_0002);
        check_irq(1'b1);
        wr(INT_CLEAR_IDX, 32'h0000_0002);
        check_irq(1'b0);
        wr(INT_ENABLE_IDX, 32'h0000_0001);
        wr(VAR_CTRL_IDX, 32'h0000_000F);
        seed = lfsr(seed);
        load_sum(seed);
        rd(VAR_DATA_IDX, {16'h0000, r[15:0]});
        rd(VAR_DATA_IDX, {16'h0000, r[31:16]});
        rd(VAR_CTRL_IDX, 32'h0000_0007);
        wr(AUTO_CTRL_IDX, 32'h0000_0001);
        wr(LQM_IDX, 32'h0000_FC00);
        rd(LQM_IDX, 32'h0000_8000);
        set_value(0, 8'hFF);
        rd(LQM_IDX, 32'h0000_8000);
        set_value(0, 8'h80);
        check_irq(1'b0);
        @(posedge clock);
        link_100_valid <= 1'b1;
        repeat (4) @(posedge clock);
        for (int b = 0; b < N_WARN; b++)
        begin
            set_value(b / 2, b[0] ? lq_bank[b / 2].high + 8'h01 : lq_bank[b / 2].low - 8'h01);
            set_value(b / 2, 8'h80);
            check_irq(1'b1);
            rd(LQM_IDX, 32'h0000_8000 | (32'h0000_0001 << b));
            rd(LQM_IDX, 32'h0000_8000);
            wr(INT_CLEAR_IDX, 32'h0000_0001);
            check_irq(1'b0);
        end
        check("link_reset", 33'(resets), 33'h0_0000_000A);
        @(posedge clock);
        lq_bank[0].high <= 8'hFF;
        lq_bank[1].low  <= 8'h00;
        set_value(0, 8'hFF);
        set_value(1, 8'h00);
        rd(LQM_IDX, 32'h0000_8000);
        check_irq(1'b0);
        wr(LQM_IDX, 32'h0000_0000);
        set_value(2, 8'h00);
        rd(LQM_IDX, 32'h0000_0000);
        check("link_reset", 33'(resets), 33'h0_0000_000A);
        repeat (2) @(posedge clock);
        stop_test();
    end
endmodule
